// [logic/lcf_pkg.sv]
/*
 Package for the laser channel fault control block: register offsets,
 field positions, reset values and the packed carriers shared by files.
 Assumes a byte-wide register port with a six-bit address.
*/
`default_nettype none

package lcf_pkg;

   localparam int unsigned ADDR_W = 6;
   localparam int unsigned DATA_W = 8;

   // Register offsets
   localparam logic [5:0] OFS_FAULT_STATUS = 6'h00;
   localparam logic [5:0] OFS_CHAN_STATUS  = 6'h01;
   localparam logic [5:0] OFS_CH1_LIMIT    = 6'h11;
   localparam logic [5:0] OFS_COMBINE      = 6'h1b;
   localparam logic [5:0] OFS_EVENT_MASK   = 6'h1d;
   localparam logic [5:0] OFS_CHAN_DISABLE = 6'h1e;
   localparam logic [5:0] OFS_FAULT_SIM    = 6'h1f;

   // fault_status fields
   localparam int unsigned FS_RAM_INIT  = 0;
   localparam int unsigned FS_SUPPLY_DN = 1;
   localparam int unsigned FS_MEM_ERR   = 2;
   localparam int unsigned FS_OVERTEMP  = 3;
   localparam int unsigned FS_CH2_OVC   = 4;
   localparam int unsigned FS_CH1_OVC   = 5;
   localparam int unsigned FS_OSC_FAULT = 6;
   localparam int unsigned FS_CFG_TIMO  = 7;

   // channel_status fields
   localparam int unsigned CS_CH1_ON  = 0;
   localparam int unsigned CS_CH1_MON = 1;
   localparam int unsigned CS_CH1_SAT = 2;
   localparam int unsigned CS_CH2_ON  = 4;
   localparam int unsigned CS_CH2_MON = 5;
   localparam int unsigned CS_CH2_SAT = 6;

   // Control fields
   localparam int unsigned CB_COMBINE  = 6;
   localparam int unsigned EM_OSC      = 0;
   localparam int unsigned EM_CH1_SAT  = 2;
   localparam int unsigned EM_CH2_SAT  = 3;
   localparam int unsigned CD_CH1      = 0;
   localparam int unsigned CD_CH2      = 1;
   localparam int unsigned SIM_CH1_OVC = 0;
   localparam int unsigned SIM_CH2_OVC = 1;
   localparam int unsigned SIM_OVT     = 2;
   localparam int unsigned SIM_OSC     = 3;

   // Reset values
   localparam logic [7:0] RST_FAULT_STATUS = 8'h03;
   localparam logic [7:0] RST_CHAN_LATCH   = 8'h00;
   localparam logic [7:0] RST_CH1_LIMIT    = 8'hff;
   localparam logic       RST_COMBINE      = 1'b0;
   localparam logic [7:0] RST_EVENT_MASK   = 8'h0c;
   localparam logic [1:0] RST_CHAN_DISABLE = 2'h3;

   // Latched bits of channel_status, cleared by a read
   localparam logic [7:0] CS_LATCH_MASK = 8'h66;

   // Pin and comparator levels arriving from outside the clock domain
   typedef struct packed {
      logic sel_open;
      logic emc_open;
      logic en1;
      logic en2;
      logic overtemp_flag;
      logic ch1_overcurrent_flag;
      logic ch2_overcurrent_flag;
      logic osc;
      logic sat1;
      logic sat2;
   } lcf_pins_s;

   localparam int unsigned PINS_W = $bits(lcf_pins_s);

   // One register access request
   typedef struct packed {
      logic             rd;
      logic             wr;
      logic [5:0]       addr;
      logic [7:0]       wdata;
   } lcf_req_s;

endpackage

`default_nettype wire

// [logic/lcf_sync.sv]
/*
 Two-flop synchroniser for a vector of independent levels.
 Assumes each bit is a slow level; no word coherence across bits.
*/
`timescale 1ns/1ns
`default_nettype none

module lcf_sync #(
   parameter int unsigned WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             sys_rst,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_q
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] meta_d;
   logic [WIDTH-1:0] sync_d;

   // Next values: first stage feeds only the second
   always_comb begin
      meta_d = async_in;
      sync_d = meta_q;
   end

   // Register both stages
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end
endmodule // lcf_sync

`default_nettype wire

// [logic/lcf_sticky.sv]
/*
 Vector of sticky flags, set by hardware events and cleared by a mask.
 Assumes set and clear come from logic on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none

module lcf_sticky #(
   parameter int unsigned       WIDTH   = 8,
   parameter logic [WIDTH-1:0]  RST_VAL = '0
) (
   input  wire logic             clk,
   input  wire logic             sys_rst,
   input  wire logic [WIDTH-1:0] set,
   input  wire logic [WIDTH-1:0] clr,
   output logic      [WIDTH-1:0] flag_q
);
   logic [WIDTH-1:0] flag_d;

   // Set wins over clear so an event in the clearing cycle survives
   always_comb begin
      flag_d = (flag_q & ~clr) | set;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         flag_q <= RST_VAL;
      end else begin
         flag_q <= flag_d;
      end
   end
endmodule // lcf_sticky

`default_nettype wire

// [logic/lcf_top.sv]
/*
 Fault and enable supervision for a dual laser channel driver: status
 latches, read acknowledge, channel gating, combined mode and the
 active-low attention output.
 Assumes pins and comparators are asynchronous levels, while the memory
 checker, config timer, standby logic and monitor enables share clk.
*/
`timescale 1ns/1ns
`default_nettype none

module lcf_top (
   input  wire logic              clk,
   input  wire logic              sys_rst,
   input  wire lcf_pkg::lcf_req_s req,
   input  wire lcf_pkg::lcf_pins_s pins_async,
   input  wire logic              mem_err_evt,
   input  wire logic              cfg_timeout_evt,
   input  wire logic              standby_exit,
   input  wire logic              ch1_monitor_on,
   input  wire logic              ch2_monitor_on,
   output logic [7:0]             rdata_q,
   output logic                   rvalid_q,
   output logic                   attention_out_n,
   output logic                   ch1_drive_q,
   output logic                   ch2_drive_q,
   output logic                   ch2_regulate_q,
   output logic                   ch2_ovc_detect_q,
   output logic [7:0]             ch1_limit_q,
   output logic                   combine_q
);
   lcf_pkg::lcf_pins_s pins_s;
   lcf_pkg::lcf_pins_s pins_prev_q;
   logic [7:0]  fault_q;
   logic [7:0]  fault_set;
   logic [7:0]  fault_clr;
   logic [7:0]  latch_q;
   logic [7:0]  latch_set;
   logic [7:0]  latch_clr;
   logic [7:0]  chan_status;
   logic [7:0]  mask_q;
   logic [7:0]  mask_d;
   logic [1:0]  dis_q;
   logic [1:0]  dis_d;
   logic [7:0]  limit_d;
   logic        combine_d;
   logic [7:0]  rdata_d;
   logic        rvalid_d;
   logic [3:0]  sim;
   logic        open_any;
   logic        err_any;
   logic        ch1_on_d;
   logic        ch2_on_d;
   logic        ch2_reg_d;
   logic        pend0_q;
   logic        pend0_d;
   logic        pend1_q;
   logic        pend1_d;
   logic        pend0_set;
   logic        pend1_set;
   logic        attn_d;
   logic        wr_hit_sim;
   logic        rd_fault;
   logic        rd_chan;

   // Pins and analog comparators cross into clk first
   lcf_sync #(
      .WIDTH    (lcf_pkg::PINS_W)
   ) u_sync (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .async_in (pins_async),
      .sync_q   (pins_s)
   );

   // Previous synchronised levels for rising edge detection
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pins_prev_q <= '0;
      end else begin
         pins_prev_q <= pins_s;
      end
   end

   // Access decode; status reads are acknowledges
   always_comb begin
      rd_fault   = req.rd && (req.addr == lcf_pkg::OFS_FAULT_STATUS);
      rd_chan    = req.rd && (req.addr == lcf_pkg::OFS_CHAN_STATUS);
      wr_hit_sim = req.wr && (req.addr == lcf_pkg::OFS_FAULT_SIM);
      sim        = wr_hit_sim ? req.wdata[3:0] : 4'h0;
   end

   // Fault event sources; overcurrent on channel 2 is ignored when
   // combined since the shared stage is guarded by channel 1 alone
   always_comb begin
      fault_set = 8'h00;
      fault_set[lcf_pkg::FS_SUPPLY_DN] = standby_exit;
      fault_set[lcf_pkg::FS_MEM_ERR]   = mem_err_evt;
      fault_set[lcf_pkg::FS_CFG_TIMO]  = cfg_timeout_evt;
      fault_set[lcf_pkg::FS_OVERTEMP]  =
         (pins_s.overtemp_flag && !pins_prev_q.overtemp_flag) || sim[lcf_pkg::SIM_OVT];
      fault_set[lcf_pkg::FS_CH1_OVC]   =
         (pins_s.ch1_overcurrent_flag && !pins_prev_q.ch1_overcurrent_flag) ||
         sim[lcf_pkg::SIM_CH1_OVC];
      fault_set[lcf_pkg::FS_CH2_OVC]   = !combine_q &&
         ((pins_s.ch2_overcurrent_flag && !pins_prev_q.ch2_overcurrent_flag) ||
          sim[lcf_pkg::SIM_CH2_OVC]);
      fault_set[lcf_pkg::FS_OSC_FAULT] =
         (pins_s.osc && !pins_prev_q.osc) || sim[lcf_pkg::SIM_OSC];
      fault_clr = rd_fault ? 8'hff : 8'h00;
   end

   // Reset value carries the power-on flags
   lcf_sticky #(
      .WIDTH   (8),
      .RST_VAL (lcf_pkg::RST_FAULT_STATUS)
   ) u_fault (
      .clk     (clk),
      .sys_rst (sys_rst),
      .set     (fault_set),
      .clr     (fault_clr),
      .flag_q  (fault_q)
   );

   // Latched channel_status bits: monitor seen and saturation
   always_comb begin
      latch_set = 8'h00;
      latch_set[lcf_pkg::CS_CH1_MON] = ch1_monitor_on;
      latch_set[lcf_pkg::CS_CH2_MON] = ch2_monitor_on;
      latch_set[lcf_pkg::CS_CH1_SAT] = pins_s.sat1 && !pins_prev_q.sat1;
      latch_set[lcf_pkg::CS_CH2_SAT] = pins_s.sat2 && !pins_prev_q.sat2;
      latch_clr = rd_chan ? lcf_pkg::CS_LATCH_MASK : 8'h00;
   end

   lcf_sticky #(
      .WIDTH   (8),
      .RST_VAL (lcf_pkg::RST_CHAN_LATCH)
   ) u_latch (
      .clk     (clk),
      .sys_rst (sys_rst),
      .set     (latch_set),
      .clr     (latch_clr),
      .flag_q  (latch_q)
   );

   // Live on-state bits joined with the latched ones
   always_comb begin
      chan_status = latch_q & lcf_pkg::CS_LATCH_MASK;
      chan_status[lcf_pkg::CS_CH1_ON] = ch1_drive_q;
      chan_status[lcf_pkg::CS_CH2_ON] = ch2_drive_q;
   end

   // Channel gating; monitor-seen bits are information, not errors
   always_comb begin
      open_any = pins_s.sel_open || pins_s.emc_open;
      err_any  = (|fault_q) || latch_q[lcf_pkg::CS_CH1_SAT] ||
                 latch_q[lcf_pkg::CS_CH2_SAT];
      ch1_on_d = !open_any && !err_any && !dis_q[lcf_pkg::CD_CH1] &&
                 pins_s.en1;
      // Combined stage needs both disables clear and both pins high
      ch2_on_d = !open_any && !err_any && !dis_q[lcf_pkg::CD_CH2] &&
                 pins_s.en2 &&
                 (!combine_q || ch1_on_d);
      ch2_reg_d = ch2_on_d && !combine_q;
   end

   // Register writes; read-only and unmapped writes are dropped
   always_comb begin
      limit_d   = ch1_limit_q;
      combine_d = combine_q;
      mask_d    = mask_q;
      dis_d     = dis_q;
      if (req.wr) begin
         case (req.addr)
            lcf_pkg::OFS_CH1_LIMIT: begin
               limit_d = req.wdata;
            end
            lcf_pkg::OFS_COMBINE: begin
               combine_d = req.wdata[lcf_pkg::CB_COMBINE];
            end
            lcf_pkg::OFS_EVENT_MASK: begin
               mask_d = req.wdata & lcf_pkg::RST_EVENT_MASK |
                        {7'h00, req.wdata[lcf_pkg::EM_OSC]};
            end
            lcf_pkg::OFS_CHAN_DISABLE: begin
               dis_d = req.wdata[1:0];
            end
            default: begin
               dis_d = dis_q;
            end
         endcase
      end
   end

   // Read data; status value is returned as it stood before its clear
   always_comb begin
      rvalid_d = req.rd;
      case (req.addr)
         lcf_pkg::OFS_FAULT_STATUS: rdata_d = fault_q;
         lcf_pkg::OFS_CHAN_STATUS:  rdata_d = chan_status;
         lcf_pkg::OFS_CH1_LIMIT:    rdata_d = ch1_limit_q;
         lcf_pkg::OFS_COMBINE:      rdata_d = {1'b0, combine_q, 6'h00};
         lcf_pkg::OFS_EVENT_MASK:   rdata_d = mask_q;
         lcf_pkg::OFS_CHAN_DISABLE: rdata_d = {6'h00, dis_q};
         default:                   rdata_d = 8'h00;
      endcase
      if (!req.rd) begin
         rdata_d = rdata_q;
      end
   end

   // Pending changes per status register; a new change beats the read,
   // and a flag set again in its own read cycle counts as a new change
   always_comb begin
      pend0_set = |(fault_set & (~fault_q | fault_clr) &
                  ~{1'b0, mask_q[lcf_pkg::EM_OSC], 6'h00});
      pend1_set = (ch1_on_d != ch1_drive_q) ||
                  (ch2_on_d != ch2_drive_q) ||
                  (|(latch_set & (~latch_q | latch_clr) &
                    ~(mask_q[3:2] == 2'b00 ? 8'h00 :
                      {1'b0, mask_q[lcf_pkg::EM_CH2_SAT], 3'h0,
                       mask_q[lcf_pkg::EM_CH1_SAT], 2'h0})));
      pend0_d = pend0_set || (pend0_q && !rd_fault);
      pend1_d = pend1_set || (pend1_q && !rd_chan);
      // Open pins hold it low with no acknowledge possible
      attn_d  = !(open_any || pend0_q || pend1_q);
   end

   // Control and output registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ch1_limit_q      <= lcf_pkg::RST_CH1_LIMIT;
         combine_q        <= lcf_pkg::RST_COMBINE;
         mask_q           <= lcf_pkg::RST_EVENT_MASK;
         dis_q            <= lcf_pkg::RST_CHAN_DISABLE;
         rdata_q          <= 8'h00;
         rvalid_q         <= 1'b0;
         ch1_drive_q      <= 1'b0;
         ch2_drive_q      <= 1'b0;
         ch2_regulate_q   <= 1'b0;
         ch2_ovc_detect_q <= 1'b1;
         pend0_q          <= 1'b1;
         pend1_q          <= 1'b1;
         attention_out_n  <= 1'b0;
      end else begin
         ch1_limit_q      <= limit_d;
         combine_q        <= combine_d;
         mask_q           <= mask_d;
         dis_q            <= dis_d;
         rdata_q          <= rdata_d;
         rvalid_q         <= rvalid_d;
         ch1_drive_q      <= ch1_on_d;
         ch2_drive_q      <= ch2_on_d;
         ch2_regulate_q   <= ch2_reg_d;
         ch2_ovc_detect_q <= !combine_d;
         pend0_q          <= pend0_d;
         pend1_q          <= pend1_d;
         attention_out_n  <= attn_d;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence open_seen;
      open_any;
   endsequence

   open_off_a: assert property (
      open_seen |=> !ch1_drive_q && !ch2_drive_q)
      else $error("channel on with open pin");
   open_attn_a: assert property (open_seen |=> !attention_out_n)
      else $error("attention high with open pin");
   disable_bit_a: assert property (dis_q[0] |=> !ch1_drive_q)
      else $error("channel 1 on while disabled");
   error_off_a: assert property (
      err_any |=> !ch1_drive_q && !ch2_drive_q)
      else $error("channel on with pending error");
   change_report_a: assert property (
      pend0_set |-> ##2 !attention_out_n)
      else $error("fault change not reported");
   read_ack_a: assert property (
      rd_fault && fault_set == 8'h00 |=> fault_q == 8'h00)
      else $error("fault read did not acknowledge");
   standby_flag_a: assert property (standby_exit |=> fault_q[1])
      else $error("standby exit did not set supply flag");
   sim_ovc_a: assert property (
      wr_hit_sim && req.wdata[0] |=> fault_q[5])
      else $error("simulated overcurrent not latched");
   combine_ovc_a: assert property (combine_q |-> !fault_set[4])
      else $error("channel 2 overcurrent seen when combined");
   attn_release_a: assert property (
      attention_out_n |-> !$past(pend0_q) && !$past(pend1_q))
      else $error("attention released with pending change");
   osc_masked_a: assert property (
      mask_q[0] && !pend0_q && !pend1_q && !open_any &&
      fault_set == 8'h40 |-> ##1 !pend0_q)
      else $error("masked oscillator fault reported");
endmodule // lcf_top

`default_nettype wire

// [verif/lcf_host.sv]
/*
 Host model: single byte reads and writes on the register port, plus the
 acknowledge and combine sequences a controller runs.
 Assumes a read answers with rvalid_q one cycle after the strobe.
*/
`timescale 1ns/1ns
`default_nettype none

module lcf_host (
   input  wire logic              clk,
   input  wire logic [7:0]        rdata_q,
   input  wire logic              rvalid_q,
   output var  lcf_pkg::lcf_req_s req
);
   // Idle port at time zero; strobes last one cycle only
   initial req = '0;

   // One write, taken at the edge after the strobe rises
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge clk) req <= '{1'b0, 1'b1, a, d};
      @(posedge clk) req.wr <= 1'b0;
   endtask

   // One read; a missing answer comes back unknown so compares fail
   task automatic rd(input logic [5:0] a, output logic [7:0] d);
      @(posedge clk) req <= '{1'b1, 1'b0, a, 8'h00};
      @(posedge clk) req.rd <= 1'b0;
      #1 d = (rvalid_q === 1'b1) ? rdata_q : 8'hxx;
   endtask

   // Acknowledge both status bytes; the gap lets a drive change land
   task automatic ack;
      logic [7:0] d;
      rd(6'h00, d);
      repeat (4) @(posedge clk);
      rd(6'h01, d);
   endtask

   // Combined setup with channel 1 threshold at half; halving the
   // current-loop reference is left to the controller, no register here
   task automatic combine(input logic [7:0] lim);
      wr(6'h1b, 8'h40);
      wr(6'h11, lim);
      wr(6'h1e, 8'h00);
   endtask
endmodule // lcf_host

`default_nettype wire

// [verif/tb_laser_channel_fault_control.sv]
/*
 Self-checking bench for the fault and enable supervision block.
 Assumes the host model drives the register port; pins come from here.
*/
`timescale 1ns/1ns
`default_nettype none

module tb_laser_channel_fault_control;
   logic               clk = 1'b0;
   logic               sys_rst = 1'b1;
   lcf_pkg::lcf_req_s  req;
   lcf_pkg::lcf_pins_s pins = '0;
   logic               mem_err = 1'b0, cfg_to = 1'b0, stby = 1'b0;
   logic               mon1 = 1'b0, mon2 = 1'b0;
   logic [7:0]         rdata_q, lim, v;
   logic               rvalid_q, att_n, d1, d2, reg2, ch2_overcurrent_flag_det, comb;
   int                 errors = 0;
   int                 n_compared = 0;

   // 100 MHz clock
   always #5 clk = ~clk;

   lcf_top lcf_top_i (.clk(clk), .sys_rst(sys_rst), .req(req),
      .pins_async(pins), .mem_err_evt(mem_err), .cfg_timeout_evt(cfg_to),
      .standby_exit(stby), .ch1_monitor_on(mon1), .ch2_monitor_on(mon2),
      .rdata_q(rdata_q), .rvalid_q(rvalid_q), .attention_out_n(att_n),
      .ch1_drive_q(d1), .ch2_drive_q(d2), .ch2_regulate_q(reg2),
      .ch2_ovc_detect_q(ch2_overcurrent_flag_det), .ch1_limit_q(lim), .combine_q(comb));

   lcf_host lcf_host_i (.clk(clk), .rdata_q(rdata_q), .rvalid_q(rvalid_q),
      .req(req));

   task automatic chk(input logic [7:0] got, exp, input string m);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("BAD t=%0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   // Let n edges pass, then sample settled outputs
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic rdc(input logic [5:0] a, input logic [7:0] e,
                      input string m);
      logic [7:0] d;
      lcf_host_i.rd(a, d);
      chk(d, e, m);
   endtask

   // Fire one fault source: 0-3 simulated, 4-6 clocked pulses, 7-8 pins
   task automatic fire(input int k);
      if (k < 4) lcf_host_i.wr(6'h1f, 8'h01 << k);
      else @(posedge clk) begin
         mem_err <= (k == 4);
         cfg_to <= (k == 5);
         stby <= (k == 6);
         pins.overtemp_flag <= (k == 7);
         pins.osc <= (k == 8);
      end
      @(posedge clk) begin
         {mem_err, cfg_to, stby} <= 3'h0;
         {pins.overtemp_flag, pins.osc} <= 2'h0;
      end
   endtask

   task automatic t_reset;
      chk({7'h0, att_n}, 8'h00, "attention after reset");
      rdc(6'h00, 8'h03, "fault reset");
      rdc(6'h01, 8'h00, "chan reset");
      rdc(6'h11, 8'hff, "limit reset");
      rdc(6'h1b, 8'h00, "combine reset");
      rdc(6'h1d, 8'h0c, "mask reset");
      rdc(6'h1e, 8'h03, "disable reset");
      lcf_host_i.wr(6'h00, 8'hff);
      rdc(6'h00, 8'h00, "status not writable");
      rdc(6'h05, 8'h00, "unmapped read");
      cyc(3);
      chk({7'h0, att_n}, 8'h01, "released after ack");
      $display("test reset done");
   endtask

   task automatic t_enable;
      @(posedge clk) begin
         pins.en1 <= 1'b1;
         pins.en2 <= 1'b1;
         mon1 <= 1'b1;
         mon2 <= 1'b1;
      end
      cyc(6);
      chk({6'h0, d1, d2}, 8'h00, "disable bits hold off");
      chk({7'h0, att_n}, 8'h00, "monitor seen reported");
      @(posedge clk) {mon1, mon2} <= 2'b00;
      lcf_host_i.wr(6'h1e, 8'h00);
      cyc(3);
      chk({4'h0, d1, d2, reg2, ch2_overcurrent_flag_det}, 8'h0f, "channels on");
      rdc(6'h01, 8'h33, "chan status on");
      cyc(3);
      chk({7'h0, att_n}, 8'h01, "released");
      $display("test enable done");
   endtask

   task automatic t_events;
      int bp[9] = '{5, 4, 3, 6, 2, 7, 1, 3, 6};
      for (int k = 0; k < 9; k++) begin
         fire(k);
         cyc(6);
         chk({6'h0, d1, d2}, 8'h00, "fault gating");
         chk({7'h0, att_n}, 8'h00, "fault reported");
         rdc(6'h00, 8'h01 << bp[k], "fault flag");
         cyc(4);
         chk({6'h0, d1, d2}, 8'h03, "on after ack");
         rdc(6'h01, 8'h11, "chan ack");
         cyc(3);
         chk({7'h0, att_n}, 8'h01, "released");
      end
      $display("test events done");
   endtask

   // Channels held off so only the event itself can pull attention
   task automatic t_masks;
      lcf_host_i.wr(6'h1e, 8'h03);
      cyc(4);
      rdc(6'h01, 8'h00, "chan off");
      @(posedge clk) {pins.sat1, pins.sat2} <= 2'b11;
      cyc(6);
      chk({7'h0, att_n}, 8'h01, "saturation masked");
      rdc(6'h01, 8'h44, "saturation latched");
      @(posedge clk) {pins.sat1, pins.sat2} <= 2'b00;
      lcf_host_i.wr(6'h1d, 8'h01);
      fire(3);
      cyc(6);
      chk({7'h0, att_n}, 8'h01, "osc masked");
      rdc(6'h00, 8'h40, "osc flagged");
      @(posedge clk) pins.sat2 <= 1'b1;
      cyc(6);
      chk({7'h0, att_n}, 8'h00, "sat2 reported");
      rdc(6'h01, 8'h40, "sat2 again");
      lcf_host_i.wr(6'h1d, 8'h0d);
      fire(2);
      cyc(6);
      chk({7'h0, att_n}, 8'h00, "critical not maskable");
      rdc(6'h00, 8'h08, "overtemp flag");
      @(posedge clk) pins.sat2 <= 1'b0;
      $display("test masks done");
   endtask

   task automatic t_open;
      lcf_host_i.wr(6'h1e, 8'h00);
      cyc(4);
      lcf_host_i.ack;
      for (int k = 0; k < 2; k++) begin
         @(posedge clk) {pins.sel_open, pins.emc_open} <= 2'b10 >> k;
         cyc(6);
         chk({6'h0, d1, d2}, 8'h00, "open pin gating");
         lcf_host_i.ack;
         cyc(3);
         chk({7'h0, att_n}, 8'h00, "open holds attention");
         rdc(6'h11, 8'hff, "port usable while open");
         @(posedge clk) {pins.sel_open, pins.emc_open} <= 2'b00;
         cyc(6);
         chk({6'h0, d1, d2}, 8'h03, "on after close");
         lcf_host_i.ack;
         cyc(3);
         chk({7'h0, att_n}, 8'h01, "released");
      end
      $display("test open done");
   endtask

   task automatic t_combine;
      lcf_host_i.combine(8'h0a);
      cyc(3);
      chk({5'h0, comb, reg2, ch2_overcurrent_flag_det}, 8'h04, "combined mode");
      chk(lim, 8'h0a, "limit code");
      rdc(6'h1b, 8'h40, "combine bit");
      lcf_host_i.wr(6'h1e, 8'h01);
      cyc(3);
      chk({6'h0, d1, d2}, 8'h00, "ch2 follows ch1");
      lcf_host_i.wr(6'h1e, 8'h00);
      cyc(3);
      lcf_host_i.ack;
      @(posedge clk) pins.ch2_overcurrent_flag <= 1'b1;
      cyc(6);
      chk({6'h0, d1, d2}, 8'h03, "ch2 overcurrent ignored");
      @(posedge clk) pins.ch1_overcurrent_flag <= 1'b1;
      cyc(6);
      chk({6'h0, d1, d2}, 8'h00, "ch1 overcurrent trips");
      rdc(6'h00, 8'h20, "ch1 overcurrent flag");
      $display("test combine done");
   endtask

   task automatic results;
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // Main sequence after six reset cycles
   initial begin
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      cyc(1);
      t_reset;
      t_enable;
      t_events;
      t_masks;
      t_open;
      t_combine;
      results;
   end

   // Watchdog, far beyond the few hundred cycles the tests need
   initial begin
      #200000;
      errors++;
      results;
   end
endmodule // tb_laser_channel_fault_control

`default_nettype wire
